// ==== inc/srx_pkg.sv ====
/*
 Constants, field encodings and carrier types for one receive lane.
 Assumes the lane logic runs on one clock taken from the shared PLL domain.
*/
package srx_pkg;

	localparam int CHAR_BITS = 10;

	// Recovery order encodings
	localparam logic [2:0] RECOV_FIRST_ORDER = 3'h0;

	// Signal-loss detection encodings
	localparam logic [1:0] LOSS_DET_OFF = 2'h0;
	localparam logic [1:0] LOSS_DET_ON  = 2'h2;

	// Character alignment encodings
	localparam logic [1:0] ALIGN_OFF    = 2'h0;
	localparam logic [1:0] ALIGN_COMMA  = 2'h1;

	// Line rate against PLL rate
	localparam logic [1:0] RATE_FULL    = 2'h0;
	localparam logic [1:0] RATE_HALF    = 2'h1;
	localparam logic [1:0] RATE_QUARTER = 2'h2;

	// Parallel width encodings
	localparam logic [2:0] WIDTH_10BIT  = 3'h0;

	// Comma patterns, bit a in position 0
	localparam logic [6:0] COMMA_POS    = 7'h7c;
	localparam logic [6:0] COMMA_NEG    = 7'h03;

	// Clock phase loaded on a line transition, per rate
	localparam logic [1:0] EDGE_PHASE_HALF    = 2'h1;
	localparam logic [1:0] EDGE_PHASE_QUARTER = 2'h1;

	// Divider terminal counts
	localparam logic [1:0] DIV_LAST_FULL    = 2'h0;
	localparam logic [1:0] DIV_LAST_HALF    = 2'h1;
	localparam logic [1:0] DIV_LAST_QUARTER = 2'h3;

	// Sampled bits without a transition before signal loss
	localparam int LOSS_RUN_DEFAULT = 64;
	localparam int RUN_CNT_BITS     = 8;

	// Values after reset
	localparam logic [3:0] BIT_CNT_RESET = 4'h0;
	localparam logic [1:0] DIV_CNT_RESET = 2'h0;
	localparam logic [CHAR_BITS-1:0] CHAR_RESET = 10'h000;

	typedef struct packed {
		logic [2:0] recovery_order_sel;
		logic [1:0] signal_loss_detect_sel;
		logic [1:0] align_sel;
		logic       rx_polarity_swap;
		logic [1:0] rate_sel;
		logic [2:0] width_sel;
		logic       lane_receiver_on;
	} srx_cfg_type;

	typedef struct packed {
		logic comma_locked;
		logic signal_lost;
		logic cfg_supported;
	} srx_status_type;

endpackage

// ==== rtl/srx_sync.sv ====
/*
 Two-flop synchroniser for the recovered serial line level.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module srx_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// ==== rtl/srx_lane.sv ====
/*
 Receive lane: rate sampling, polarity, comma alignment, signal-loss
 detection and 10-bit character delivery under software configuration.
 Assumes cfg comes from logic on clk and rx_serial_in is a raw line level.
*/
`timescale 1ns/1ps
// Functional notes
// - Recovery order 000 gives first-order clock and data recovery.
// - Signal-loss detection off at 00, on at 10.
// - Alignment 01 hunts commas and aligns to 10-bit characters.
// - Polarity bit 1 inverts every received bit, 0 passes unchanged.
// - Line rate is PLL rate, half of it, or quarter of it.
// - Width 000 delivers 10-bit character groups.
// - Receiver enable bit turns the lane receiver off or on.
module srx_lane #(
	parameter int LOSS_RUN = srx_pkg::LOSS_RUN_DEFAULT
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire srx_pkg::srx_cfg_type     cfg,
	input  wire logic                     rx_serial_in,
	output logic [srx_pkg::CHAR_BITS-1:0] rx_char_reg,
	output logic                          rx_char_valid_reg,
	output srx_pkg::srx_status_type       status_reg
);

	logic                          line_s;
	logic                          line_bit;
	logic                          prev_bit_reg;
	logic                          edge_seen;
	logic [1:0]                    div_cnt_reg;
	logic [1:0]                    div_cnt_next;
	logic [1:0]                    div_last;
	logic [1:0]                    edge_phase;
	logic                          sample_stb;
	logic [srx_pkg::CHAR_BITS-1:0] shift_reg;
	logic [srx_pkg::CHAR_BITS-1:0] shift_next;
	logic [3:0]                    bit_cnt_reg;
	logic                          comma_hit;
	logic                          char_done;
	logic                          last_sample_reg;
	logic                          comma_locked_reg;
	logic                          signal_lost_reg;
	logic                          cfg_supported_reg;

	localparam int RUN_W = srx_pkg::RUN_CNT_BITS;
	localparam logic [RUN_W-1:0] RUN_LIMIT = RUN_W'(LOSS_RUN);

	logic [RUN_W-1:0]              run_cnt_reg;

	// Status flags gathered into one carrier
	assign status_reg = srx_pkg::srx_status_type'({comma_locked_reg, signal_lost_reg,
		cfg_supported_reg});

	srx_sync line_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (rx_serial_in),
		.sync_out (line_s)
	);

	assign line_bit = line_s ^ cfg.rx_polarity_swap;
	assign edge_seen = line_bit != prev_bit_reg;

	always_comb begin
		div_last   = srx_pkg::DIV_LAST_FULL;
		edge_phase = srx_pkg::EDGE_PHASE_HALF;
		unique case (cfg.rate_sel)
			srx_pkg::RATE_HALF: begin
				div_last   = srx_pkg::DIV_LAST_HALF;
				edge_phase = srx_pkg::EDGE_PHASE_HALF;
			end
			srx_pkg::RATE_QUARTER: begin
				div_last   = srx_pkg::DIV_LAST_QUARTER;
				edge_phase = srx_pkg::EDGE_PHASE_QUARTER;
			end
			default: begin
				div_last   = srx_pkg::DIV_LAST_FULL;
				edge_phase = srx_pkg::EDGE_PHASE_HALF;
			end
		endcase
	end

	assign sample_stb = cfg.lane_receiver_on && (div_cnt_reg >= div_last);

	always_comb begin
		if (sample_stb || div_last == srx_pkg::DIV_LAST_FULL) begin
			div_cnt_next = srx_pkg::DIV_CNT_RESET;
		end else if (edge_seen) begin
			div_cnt_next = edge_phase;
		end else begin
			div_cnt_next = div_cnt_reg + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_cnt_reg  <= srx_pkg::DIV_CNT_RESET;
			prev_bit_reg <= 1'b0;
		end else if (!cfg.lane_receiver_on) begin
			div_cnt_reg  <= srx_pkg::DIV_CNT_RESET;
			prev_bit_reg <= line_bit;
		end else begin
			div_cnt_reg  <= div_cnt_next;
			prev_bit_reg <= line_bit;
		end
	end

	assign shift_next = {line_bit, shift_reg[srx_pkg::CHAR_BITS-1:1]};
	assign comma_hit  = (cfg.align_sel == srx_pkg::ALIGN_COMMA)
		&& (shift_next[6:0] == srx_pkg::COMMA_POS || shift_next[6:0] == srx_pkg::COMMA_NEG);
	assign char_done  = comma_hit || bit_cnt_reg == 4'(srx_pkg::CHAR_BITS - 1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_reg   <= srx_pkg::CHAR_RESET;
			bit_cnt_reg <= srx_pkg::BIT_CNT_RESET;
		end else if (!cfg.lane_receiver_on) begin
			bit_cnt_reg <= srx_pkg::BIT_CNT_RESET;
		end else if (sample_stb) begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= char_done ? srx_pkg::BIT_CNT_RESET : bit_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_char_reg       <= srx_pkg::CHAR_RESET;
			rx_char_valid_reg <= 1'b0;
		end else begin
			rx_char_valid_reg <= sample_stb && char_done
				&& cfg.width_sel == srx_pkg::WIDTH_10BIT;
			if (sample_stb && char_done) begin
				rx_char_reg <= shift_next;
			end
		end
	end

	// alignment lock cleared while the lane receiver is off
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			comma_locked_reg <= 1'b0;
		end else if (!cfg.lane_receiver_on) begin
			comma_locked_reg <= 1'b0;
		end else if (sample_stb && comma_hit) begin
			comma_locked_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			last_sample_reg <= 1'b0;
			run_cnt_reg     <= '0;
			signal_lost_reg <= 1'b0;
		end else if (!cfg.lane_receiver_on
				|| cfg.signal_loss_detect_sel != srx_pkg::LOSS_DET_ON) begin
			run_cnt_reg     <= '0;
			signal_lost_reg <= 1'b0;
		end else if (sample_stb) begin
			last_sample_reg <= line_bit;
			if (line_bit != last_sample_reg) begin
				run_cnt_reg     <= '0;
				signal_lost_reg <= 1'b0;
			end else if (run_cnt_reg >= RUN_LIMIT) begin
				signal_lost_reg <= 1'b1;
			end else begin
				run_cnt_reg <= run_cnt_reg + RUN_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_supported_reg <= 1'b0;
		end else begin
			cfg_supported_reg <=
				cfg.recovery_order_sel == srx_pkg::RECOV_FIRST_ORDER
				&& cfg.width_sel == srx_pkg::WIDTH_10BIT
				&& cfg.rate_sel != 2'h3;
		end
	end

endmodule

// ==== test/srx_lane_monitor.sv ====
/*
 Port checker for the receive lane, bound to srx_lane.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module srx_lane_monitor #(
	parameter int LOSS_RUN = srx_pkg::LOSS_RUN_DEFAULT
) (
	input wire logic                          clk,
	input wire logic                          sys_rst,
	input wire srx_pkg::srx_cfg_type          cfg,
	input wire logic                          rx_serial_in,
	input wire logic [srx_pkg::CHAR_BITS-1:0] rx_char_reg,
	input wire logic                          rx_char_valid_reg,
	input wire srx_pkg::srx_status_type       status_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic on, lon, wid, sup;
	assign on = cfg.lane_receiver_on;
	assign lon = cfg.signal_loss_detect_sel == srx_pkg::LOSS_DET_ON;
	assign wid = cfg.width_sel != srx_pkg::WIDTH_10BIT;
	assign sup = !cfg.recovery_order_sel && !wid && cfg.rate_sel != 2'h3;
	a_off_idle: assert property (!on && $past(!on) |-> !rx_char_valid_reg &&
		!status_reg.comma_locked && !status_reg.signal_lost) else $error("Idle lane active");
	a_valid_pulse: assert property (rx_char_valid_reg |=> !rx_char_valid_reg
		|| rx_char_reg[6:0] == srx_pkg::COMMA_POS || rx_char_reg[6:0] == srx_pkg::COMMA_NEG)
		else $error("Back-to-back valid without comma");
	a_loss_gated: assert property (!lon && $past(!lon) |-> !status_reg.signal_lost)
		else $error("Loss flag while detection off");
	a_loss_cause: assert property ($rose(status_reg.signal_lost) |-> $past(lon && on))
		else $error("Loss flag without detection");
	a_width_gate: assert property (wid && $past(wid) |-> !rx_char_valid_reg)
		else $error("Valid with unsupported width");
	a_cfg_supp: assert property (!$past(sys_rst) |-> status_reg.cfg_supported == $past(sup))
		else $error("Supported flag wrong");
	a_lock_sticky: assert property (status_reg.comma_locked && on |=> status_reg.comma_locked)
		else $error("Lock dropped while enabled");
	a_lock_cause: assert property ($rose(status_reg.comma_locked) |->
		$past(cfg.align_sel == srx_pkg::ALIGN_COMMA && on)) else $error("Lock without search");
	c_lock: cover property ($rose(status_reg.comma_locked));
	c_lost: cover property ($rose(status_reg.signal_lost));
	c_quarter: cover property (rx_char_valid_reg && cfg.rate_sel == srx_pkg::RATE_QUARTER);
endmodule
bind srx_lane srx_lane_monitor #(.LOSS_RUN(LOSS_RUN)) u_mon (.clk(clk), .sys_rst(sys_rst),
	.cfg(cfg), .rx_serial_in(rx_serial_in), .rx_char_reg(rx_char_reg),
	.rx_char_valid_reg(rx_char_valid_reg), .status_reg(status_reg));

// ==== test/srx_link_tx.sv ====
/*
 Far-end transmitter model, first bit of a character first.
 Assumes put is called just after a rising clk edge.
*/
`timescale 1ns/1ps
module srx_link_tx (
	input  wire logic clk,
	input  wire logic inv,
	output logic      line
);
	initial begin
		line = 1'b0;
	end
	task automatic put(input logic [9:0] w, input int per);
		for (int i = 0; i < 10; i++) begin
			line <= w[i] ^ inv;
			repeat (per) @(posedge clk);
		end
	endtask
endmodule

// ==== test/serdes_rx_channel_config_tb.sv ====
/*
 Self-checking bench for the receive lane.
 Assumes the checker is bound and the far end is srx_link_tx.
*/
`timescale 1ns/1ps
module serdes_rx_channel_config_tb;
	localparam int LOSS = 8;
	logic                 clk, sys_rst, line, rx_valid, flip;
	srx_pkg::srx_cfg_type cfg;
	srx_pkg::srx_status_type st;
	logic [9:0]           rx_char, last [4], d [3];
	logic [1:0]           pol;
	int                   n_errors, n_tests, n_valid, cyc, seed, per;
	srx_link_tx u_tx (.clk(clk), .inv(flip), .line(line));
	srx_lane #(.LOSS_RUN(LOSS)) u_dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
		.rx_serial_in(line), .rx_char_reg(rx_char), .rx_char_valid_reg(rx_valid),
		.status_reg(st));
	task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic run_lane(input logic [1:0] rate, input logic [2:0] width);
		int base;
		logic [9:0] x;
		base = n_valid;
		per = 1 << rate;
		cfg.rate_sel <= rate;
		cfg.width_sel <= width;
		cfg.align_sel <= srx_pkg::ALIGN_OFF;
		cfg.lane_receiver_on <= 1'b1;
		@(posedge clk);
		// Flush old bits before the comma hunt
		u_tx.put(10'h000, per);
		cfg.align_sel <= srx_pkg::ALIGN_COMMA;
		u_tx.put(10'h17c, per);
		for (int i = 0; i < 3; i++) begin
			d[i] = 10'(($random(seed) & ~10'h0a5) | 10'h021);
			u_tx.put(d[i], per);
			if (i == 0) begin
				cfg.align_sel <= srx_pkg::ALIGN_OFF;
			end
		end
		repeat (4 * per + 4) @(posedge clk);
		x = {10{cfg.rx_polarity_swap ^ flip}};
		cmp("valid count", 10'(width == 3'h0 ? 4 : 0), 10'(n_valid - base));
		cmp("locked", 10'h1, 10'(st.comma_locked));
		cmp("supported", 10'(width == 3'h0), 10'(st.cfg_supported));
		if (width == 3'h0) begin
			cmp("comma", 10'h17c ^ x, last[0]);
			for (int i = 0; i < 3; i++) begin
				cmp("char", d[i] ^ x, last[i + 1]);
			end
		end
		cfg.lane_receiver_on <= 1'b0;
		repeat (3) @(posedge clk);
		cmp("locked off", 10'h0, 10'(st.comma_locked));
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		// Only characters from the comma onwards count
		if (rx_valid === 1'b1 && st.comma_locked === 1'b1) begin
			n_valid++;
			last <= '{last[1], last[2], last[3], rx_char};
		end
		if (cyc > 6000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		seed = 21714;
		n_errors = 0;
		n_tests = 0;
		n_valid = 0;
		cyc = 0;
		flip = 1'b0;
		sys_rst = 1'b1;
		cfg = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			pol = 2'($random(seed));
			flip <= pol[0] & ~pol[1];
			cfg.rx_polarity_swap <= pol[1];
			run_lane(2'(k % 3), k == 5 ? 3'h1 : 3'h0);
		end
		cfg.signal_loss_detect_sel <= srx_pkg::LOSS_DET_ON;
		cfg.rate_sel <= srx_pkg::RATE_FULL;
		cfg.width_sel <= srx_pkg::WIDTH_10BIT;
		cfg.lane_receiver_on <= 1'b1;
		repeat (LOSS + 8) @(posedge clk);
		cmp("lost", 10'h1, 10'(st.signal_lost));
		u_tx.put(10'h2aa, 1);
		cmp("lost clear", 10'h0, 10'(st.signal_lost));
		cfg.rate_sel <= 2'h3;
		repeat (2) @(posedge clk);
		cmp("rate 11", 10'h0, 10'(st.cfg_supported));
		tally_and_finish();
	end
endmodule
